// ==== design/adc_gain_offset_trim_regs.sv ====
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Gain applies only while gain enable set
// - Gain code N scales by N x 0.2 dB
// - Offset subtracted while offset enable set
// - Offset field is signed two's complement
// - One offset count is one 14-bit LSB
// - Index 32h trims channel 13 even samples
// - Index 33h trims channel 14 odd samples
// - Index 34h trims channel 14 even samples
// - Index 35h trims channel 15 odd samples
// - Index 31h trims channel 13 odd samples
module adc_gain_offset_trim_regs
	import trim_pkg::*;
#(
	parameter int AW = 12,
	parameter int SW = SAMPLE_W
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic [AW-1:0]        awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [AW-1:0]        araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	input  wire logic                 sampleValid,
	input  wire logic [2:0]           sampleSlot,
	input  wire logic signed [SW-1:0] sampleData,
	output logic                      trimValid,
	output logic signed [SW-1:0]      trimData
);
	typedef struct packed {
		logic          awReady;
		logic          wReady;
		logic          awHeld;
		logic          wHeld;
		logic [AW-1:0] awAddr;
		logic [31:0]   wData;
		logic [3:0]    wStrb;
		logic          bValid;
		logic [1:0]    bResp;
		logic          arReady;
		logic          rValid;
		logic [31:0]   rData;
		logic [1:0]    rResp;
		logic          wrEn;
		logic [2:0]    wrSlot;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic [2:0] rdSlot;
	logic [2:0] wrSlotC;

	trim_if tif ();

	// Byte address to slot; misaligned or out-of-range is unmapped
	function automatic logic [2:0] addrSlot(input logic [AW-1:0] a);
		logic [2:0] s;
		s = slotOf(a[9:2]);
		if (a[1:0] != 2'h0 || (a >> 10) != '0) begin
			s = SLOT_NONE;
		end
		return s;
	endfunction

	// Bus slave: one write and one read in flight, one-cycle answer
	always_comb begin
		nxt_st = st_ff;
		nxt_st.wrEn = 1'b0;
		rdSlot = addrSlot(araddr);
		// Write address and data are taken in either order
		if (awvalid && st_ff.awReady) begin
			nxt_st.awHeld = 1'b1;
			nxt_st.awAddr = awaddr;
		end
		if (wvalid && st_ff.wReady) begin
			nxt_st.wHeld = 1'b1;
			nxt_st.wData = wdata;
			nxt_st.wStrb = wstrb;
		end
		if (bready && st_ff.bValid) begin
			nxt_st.bValid = 1'b0;
		end
		wrSlotC = addrSlot(nxt_st.awAddr);
		// Both halves present: commit and answer
		if (nxt_st.awHeld && nxt_st.wHeld && !nxt_st.bValid) begin
			nxt_st.awHeld = 1'b0;
			nxt_st.wHeld = 1'b0;
			nxt_st.bValid = 1'b1;
			nxt_st.wrSlot = wrSlotC;
			nxt_st.wrEn = wrSlotC != SLOT_NONE;
			nxt_st.bResp = (wrSlotC != SLOT_NONE) ? RESP_OKAY : RESP_SLVERR;
		end
		// Ready stays low while the response waits, so payload is stable
		nxt_st.awReady = !nxt_st.awHeld && !nxt_st.bValid;
		nxt_st.wReady = !nxt_st.wHeld && !nxt_st.bValid;
		if (rready && st_ff.rValid) begin
			nxt_st.rValid = 1'b0;
		end
		if (arvalid && st_ff.arReady) begin
			nxt_st.rValid = 1'b1;
			nxt_st.rResp = RESP_OKAY;
			nxt_st.rData = 32'h0000_0000;
			// stored fields read back regardless of enables
			if (rdSlot < SLOT_CTRL) begin
				nxt_st.rData[15:0] = tif.word[rdSlot];
			end else if (rdSlot == SLOT_CTRL) begin
				nxt_st.rData[CTRL_GAIN_EN_BIT] = tif.gainEn;
				nxt_st.rData[CTRL_OFF_EN_BIT] = tif.offEn;
			end else if (rdSlot == SLOT_RES) begin
				nxt_st.rData[1:0] = tif.res;
			end else begin
				nxt_st.rResp = RESP_SLVERR;
			end
		end
		nxt_st.arReady = !nxt_st.rValid;
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Bus outputs straight from the state register
	assign awready = st_ff.awReady;
	assign wready  = st_ff.wReady;
	assign bvalid  = st_ff.bValid;
	assign bresp   = st_ff.bResp;
	assign arready = st_ff.arReady;
	assign rvalid  = st_ff.rValid;
	assign rdata   = st_ff.rData;
	assign rresp   = st_ff.rResp;

	// Register storage; write ports come from the state register
	trim_regfile u_regs (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wrEn    (st_ff.wrEn),
		.wrSlot  (st_ff.wrSlot),
		.wrData  (st_ff.wData[15:0]),
		.wrStrb  (st_ff.wStrb[1:0]),
		.tif     (tif.store)
	);

	// Sample correction, two cycles of latency
	trim_calc #(
		.SW (SW)
	) u_calc (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.tif      (tif.user),
		.inValid  (sampleValid),
		.inSlot   (sampleSlot),
		.inData   (sampleData),
		.outValid (trimValid),
		.outData  (trimData)
	);

	ch13_even_wr_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		($rose(st_ff.bValid) && st_ff.bResp == RESP_OKAY && st_ff.wStrb[1:0] == 2'h3
			&& st_ff.awAddr == AW'({IDX_CH13_EVEN, 2'h0}))
		|=> (tif.word[SLOT_CH13_EVEN] == st_ff.wData[15:0]))
		else $error("write to 32h missed channel 13 even");
	ch14_odd_hi_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		($rose(st_ff.bValid) && st_ff.bResp == RESP_OKAY && st_ff.wStrb[1:0] == 2'h2
			&& st_ff.awAddr == AW'({IDX_CH14_ODD, 2'h0}))
		|=> (tif.word[SLOT_CH14_ODD][15:8] == st_ff.wData[15:8]
			&& $stable(tif.word[SLOT_CH14_ODD][7:0])))
		else $error("upper byte write to 33h wrong");
	ch14_even_lo_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		($rose(st_ff.bValid) && st_ff.bResp == RESP_OKAY && st_ff.wStrb[1:0] == 2'h1
			&& st_ff.awAddr == AW'({IDX_CH14_EVEN, 2'h0}))
		|=> (tif.word[SLOT_CH14_EVEN][7:0] == st_ff.wData[7:0]
			&& $stable(tif.word[SLOT_CH14_EVEN][15:8])))
		else $error("lower byte write to 34h wrong");
	ch15_odd_rd_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(arvalid && arready && araddr == AW'({IDX_CH15_ODD, 2'h0}))
		|=> (rvalid && rresp == RESP_OKAY
			&& rdata == {16'h0000, $past(tif.word[SLOT_CH15_ODD])}))
		else $error("read of 35h wrong");
	ch13_odd_wr_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		($rose(st_ff.bValid) && st_ff.bResp == RESP_OKAY && st_ff.wStrb[1:0] == 2'h3
			&& st_ff.awAddr == AW'({IDX_CH13_ODD, 2'h0}))
		|=> (tif.word[SLOT_CH13_ODD] == st_ff.wData[15:0]))
		else $error("write to 31h missed channel 13 odd");
endmodule
`default_nettype wire

// ==== design/trim_calc.sv ====
`timescale 1ns/100ps
`default_nettype none
module trim_calc
	import trim_pkg::*;
#(
	parameter int SW = SAMPLE_W
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	trim_if.user                      tif,
	input  wire logic                 inValid,
	input  wire logic [2:0]           inSlot,
	input  wire logic signed [SW-1:0] inData,
	output logic                      outValid,
	output logic signed [SW-1:0]      outData
);
	localparam int PW = SW + 19;

	typedef struct packed {
		logic                 s1Valid;
		logic signed [SW+1:0] s1Diff;
		logic [15:0]          s1Coef;
		res_t                 s1Res;
		logic                 oValid;
		logic signed [SW-1:0] oData;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic                 slotOk;
	logic signed [9:0]    curOff;
	logic [4:0]           curGain;
	logic signed [SW+1:0] scaledOff;
	logic signed [PW-1:0] prod;
	logic signed [PW-1:0] rounded;
	logic signed [PW-1:0] maxV;

	// Two stages: offset subtract, then gain with rounding and clamp
	always_comb begin
		nxt_st = st_ff;
		slotOk = inSlot < SLOT_CTRL;
		curOff = '0;
		curGain = '0;
		if (slotOk) begin
			curOff  = tif.word[inSlot][OFF_MSB:0];
			curGain = tif.word[inSlot][GAIN_MSB:GAIN_LSB];
		end
		scaledOff = (SW+2)'(curOff) >>> resShift(tif.res);
		nxt_st.s1Diff = (SW+2)'(inData) - ((tif.offEn && slotOk) ? scaledOff : '0);
		nxt_st.s1Coef = (tif.gainEn && slotOk) ? GAIN_COEF[curGain] : COEF_UNITY;
		nxt_st.s1Valid = inValid;
		nxt_st.s1Res = tif.res;
		// Both factors widened first so the product keeps every bit
		prod = PW'(st_ff.s1Diff) * PW'($signed({1'b0, st_ff.s1Coef}));
		// Signed rounding term, else the shift turns logical for negative products
		rounded = (prod + $signed(PW'(COEF_UNITY >> 1))) >>> COEF_FRAC;
		// Clamp rather than wrap, as wrap would flip the sign
		maxV = PW'((1 << (SW - 1)) - 1) >>> resShift(st_ff.s1Res);
		if (rounded > maxV) begin
			nxt_st.oData = SW'(maxV);
		end else if (rounded < -maxV - 1) begin
			nxt_st.oData = SW'(-maxV - 1);
		end else begin
			nxt_st.oData = SW'(rounded);
		end
		nxt_st.oValid = st_ff.s1Valid;
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign outValid = st_ff.oValid;
	assign outData  = st_ff.oData;

	gain_off_pass_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(inValid && !tif.gainEn && !tif.offEn && tif.res == RES14 && curGain != 5'h0)
		|-> ##2 (outValid && outData == $past(inData, 2)))
		else $error("gain applied while disabled");
	gain_step_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(inValid && slotOk && tif.gainEn && !tif.offEn && tif.res == RES14
			&& curGain == 5'd30 && inData < 14'sd4000 && inData > -14'sd4000)
		|-> ##2 (int'(outData) == ((int'($past(inData, 2)) * 32690 + 8192) >>> 14)))
		else $error("gain of 6.0 dB wrong");
	off_sub_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(inValid && slotOk && tif.offEn && !tif.gainEn && tif.res == RES14
			&& inData < 14'sd4000 && inData > -14'sd4000)
		|-> ##2 (int'(outData) == int'($past(inData, 2)) - int'($past(curOff, 2))))
		else $error("offset not subtracted");
	off_signed_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(inValid && slotOk && tif.offEn && !tif.gainEn && tif.res == RES14
			&& curOff < 0 && inData < 14'sd4000 && inData > -14'sd4000)
		|-> ##2 (outData > $past(inData, 2)))
		else $error("negative offset did not add");
	off_scale_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(inValid && slotOk && tif.offEn && !tif.gainEn && tif.res == RES12
			&& inData < 14'sd1000 && inData > -14'sd1000)
		|-> ##2 (int'(outData) == int'($past(inData, 2)) - (int'($past(curOff, 2)) >>> 2)))
		else $error("offset not scaled for 12 bit");
	off_pass_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(inValid && !tif.offEn && !tif.gainEn && tif.res == RES14 && curOff != 10'sd0)
		|-> ##2 (outValid && outData == $past(inData, 2)))
		else $error("offset applied while disabled");
endmodule
`default_nettype wire

// ==== design/trim_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Stored trim words and enables, from the register file to its users
interface trim_if;
	import trim_pkg::*;
	logic [NUM_TRIM-1:0][15:0] word;
	logic                      gainEn;
	logic                      offEn;
	res_t                      res;
	modport store (output word, output gainEn, output offEn, output res);
	modport user  (input word, input gainEn, input offEn, input res);
endinterface
`default_nettype wire

// ==== design/trim_pkg.sv ====
`default_nettype none
package trim_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL      = 8'h03;
	localparam logic [7:0] IDX_CH13_ODD  = 8'h31;
	localparam logic [7:0] IDX_CH13_EVEN = 8'h32;
	localparam logic [7:0] IDX_CH14_ODD  = 8'h33;
	localparam logic [7:0] IDX_CH14_EVEN = 8'h34;
	localparam logic [7:0] IDX_CH15_ODD  = 8'h35;
	localparam logic [7:0] IDX_RES       = 8'h40;
	// Internal storage slots
	localparam logic [2:0] SLOT_CH13_ODD  = 3'h0;
	localparam logic [2:0] SLOT_CH13_EVEN = 3'h1;
	localparam logic [2:0] SLOT_CH14_ODD  = 3'h2;
	localparam logic [2:0] SLOT_CH14_EVEN = 3'h3;
	localparam logic [2:0] SLOT_CH15_ODD  = 3'h4;
	localparam logic [2:0] SLOT_CTRL      = 3'h5;
	localparam logic [2:0] SLOT_RES       = 3'h6;
	localparam logic [2:0] SLOT_NONE      = 3'h7;
	localparam int NUM_TRIM = 5;
	localparam int SAMPLE_W = 14;
	// Field positions
	localparam int GAIN_MSB         = 15;
	localparam int GAIN_LSB         = 11;
	localparam int OFF_MSB          = 9;
	localparam int CTRL_GAIN_EN_BIT = 12;
	localparam int CTRL_OFF_EN_BIT  = 8;
	// Reset values, bus response codes and resolution settings
	localparam logic [15:0] TRIM_RESET = 16'h0000;
	localparam logic        EN_RESET   = 1'b0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {RES14 = 2'h0, RES12 = 2'h1, RES10 = 2'h2} res_t;
	localparam res_t RES_RESET = RES14;
	localparam int RES12_SHIFT = 2;
	localparam int RES10_SHIFT = 4;
	// Gain in Q2.14: round(16384 * 10^(N*0.2/20)), N = 31 down to 0
	localparam int COEF_FRAC = 14;
	localparam logic [15:0] COEF_UNITY = 16'h4000;
	localparam logic [31:0][15:0] GAIN_COEF = {
		16'h82AC, 16'h7FB2, 16'h7CCA, 16'h79F3, 16'h772C, 16'h7476, 16'h71CF, 16'h6F38,
		16'h6CB0, 16'h6A37, 16'h67CC, 16'h656F, 16'h6320, 16'h60DE, 16'h5EAA, 16'h5C82,
		16'h5A67, 16'h5858, 16'h5655, 16'h545E, 16'h5273, 16'h5092, 16'h4EBD, 16'h4CF2,
		16'h4B32, 16'h497B, 16'h47CF, 16'h462D, 16'h4494, 16'h4304, 16'h417E, 16'h4000};

	// Register index to storage slot
	function automatic logic [2:0] slotOf(input logic [7:0] idx);
		logic [2:0] s;
		s = SLOT_NONE;
		if (idx == IDX_CH13_ODD) begin
			s = SLOT_CH13_ODD;
		end else if (idx == IDX_CH13_EVEN) begin
			s = SLOT_CH13_EVEN;
		end else if (idx == IDX_CH14_ODD) begin
			s = SLOT_CH14_ODD;
		end else if (idx == IDX_CH14_EVEN) begin
			s = SLOT_CH14_EVEN;
		end else if (idx == IDX_CH15_ODD) begin
			s = SLOT_CH15_ODD;
		end else if (idx == IDX_CTRL) begin
			s = SLOT_CTRL;
		end else if (idx == IDX_RES) begin
			s = SLOT_RES;
		end
		return s;
	endfunction

	// Offset shift for coarser output resolutions
	function automatic int resShift(input res_t r);
		return (r == RES12) ? RES12_SHIFT : (r == RES10) ? RES10_SHIFT : 0;
	endfunction
endpackage
`default_nettype wire

// ==== design/trim_regfile.sv ====
`timescale 1ns/100ps
`default_nettype none
module trim_regfile
	import trim_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        wrEn,
	input  wire logic [2:0]  wrSlot,
	input  wire logic [15:0] wrData,
	input  wire logic [1:0]  wrStrb,
	trim_if.store            tif
);
	typedef struct packed {
		logic [NUM_TRIM-1:0][15:0] word;
		logic                      gainEn;
		logic                      offEn;
		res_t                      res;
	} state_t;

	localparam state_t ST_RESET = '{word: {NUM_TRIM{TRIM_RESET}}, gainEn: EN_RESET,
		offEn: EN_RESET, res: RES_RESET};

	state_t st_ff;
	state_t nxt_st;

	// Byte-lane writes; bit 10 is stored as written, nothing uses it
	always_comb begin
		nxt_st = st_ff;
		if (wrEn) begin
			if (wrSlot < SLOT_CTRL) begin
				for (int b = 0; b < 2; b++) begin
					if (wrStrb[b]) begin
						nxt_st.word[wrSlot][b*8 +: 8] = wrData[b*8 +: 8];
					end
				end
			end else if (wrSlot == SLOT_CTRL && wrStrb[1]) begin
				nxt_st.gainEn = wrData[CTRL_GAIN_EN_BIT];
				nxt_st.offEn  = wrData[CTRL_OFF_EN_BIT];
			end else if (wrSlot == SLOT_RES && wrStrb[0] && wrData[1:0] != 2'h3) begin
				// Unused code ignored so resolution is always legal
				nxt_st.res = res_t'(wrData[1:0]);
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Stored values drive users directly
	assign tif.word   = st_ff.word;
	assign tif.gainEn = st_ff.gainEn;
	assign tif.offEn  = st_ff.offEn;
	assign tif.res    = st_ff.res;
endmodule
`default_nettype wire

// ==== sim/adc_gain_offset_trim_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module adc_gain_offset_trim_regs_tb;
	import trim_pkg::*;
	logic               clk         = 1'b0;
	logic               sys_rst     = 1'b1;
	logic [11:0]        awaddr      = 12'h000;
	logic               awvalid     = 1'b0;
	logic               awready;
	logic [31:0]        wdata       = 32'h0000_0000;
	logic [3:0]         wstrb       = 4'h0;
	logic               wvalid      = 1'b0;
	logic               wready;
	logic [1:0]         bresp;
	logic               bvalid;
	logic               bready      = 1'b0;
	logic [11:0]        araddr      = 12'h000;
	logic               arvalid     = 1'b0;
	logic               arready;
	logic [31:0]        rdata;
	logic [1:0]         rresp;
	logic               rvalid;
	logic               rready      = 1'b0;
	logic               sampleValid = 1'b0;
	logic [2:0]         sampleSlot  = 3'h0;
	logic signed [13:0] sampleData  = 14'sh0000;
	logic               trimValid;
	logic signed [13:0] trimData;
	int                 errors      = 0;
	int                 comparisons = 0;
	// Shadow of what software wrote, so expectations never come from the design
	logic [4:0][15:0]   shadow;
	logic               gEnM        = 1'b0;
	logic               oEnM        = 1'b0;
	int                 shiftM      = 0;
	// bit 10 zero
	// Trim words, bit 10 kept zero as software must; slot k at index 31h+k
	localparam logic [4:0][15:0] TRIM_VAL = {16'h8040, 16'h29FF, 16'h0200, 16'hF014, 16'hFBFB};

	adc_gain_offset_trim_regs #(.AW(12), .SW(14)) adc_gain_offset_trim_regs_i (
		.clk(clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sampleValid(sampleValid), .sampleSlot(sampleSlot), .sampleData(sampleData),
		.trimValid(trimValid), .trimData(trimData)
	);

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Write with both channels offered together; a bounded wait guards a hang
	task automatic wrChk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] expResp);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 50) begin
			@(posedge clk);
			n++;
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
			if (bvalid && bready) begin
				bready <= 1'b0;
				chk("bresp", 32'(expResp), 32'(bresp));
				n = 100;
			end
		end
		if (n != 100) begin
			chk("write answer", 32'h0000_0001, 32'h0000_0000);
		end
		// An edge passes so a following call never re-raises bready in this step
		@(posedge clk);
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [31:0] expData,
			input logic [1:0] expResp);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 50) begin
			@(posedge clk);
			n++;
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
			if (rvalid && rready) begin
				rready <= 1'b0;
				chk("rdata", expData, rdata);
				chk("rresp", 32'(expResp), 32'(rresp));
				n = 100;
			end
		end
		if (n != 100) begin
			chk("read answer", 32'h0000_0001, 32'h0000_0000);
		end
		// An edge passes so a following call never re-raises rready in this step
		@(posedge clk);
	endtask

	// Reference arithmetic: offset first, then gain, rounding half up, saturating
	function automatic logic [13:0] model(input logic [2:0] slot, input int x);
		int     d;
		int     off;
		int     c;
		longint p;
		if (slot > 3'h4) begin
			return 14'(x);
		end
		off = int'($signed(shadow[slot][9:0]));
		d = x - (oEnM ? (off >>> shiftM) : 0);
		c = gEnM ? int'(GAIN_COEF[shadow[slot][15:11]]) : 16384;
		p = (longint'(d) * c + 8192) >>> 14;
		if (p > (8191 >>> shiftM)) begin
			p = 8191 >>> shiftM;
		end
		if (p < (-8192 >>> shiftM)) begin
			p = -8192 >>> shiftM;
		end
		return 14'(p);
	endfunction

	// Two samples back to back; each answer is due exactly two cycles after it
	task automatic pair(input logic [2:0] s1, input int x1, input logic [2:0] s2, input int x2);
		logic signed [13:0] e1;
		logic signed [13:0] e2;
		e1 = model(s1, x1);
		e2 = model(s2, x2);
		sampleValid <= 1'b1;
		sampleSlot <= s1;
		sampleData <= 14'(x1);
		@(posedge clk);
		sampleSlot <= s2;
		sampleData <= 14'(x2);
		#1;
		chk("trimValid early", 32'h0000_0000, 32'(trimValid));
		@(posedge clk);
		sampleValid <= 1'b0;
		#1;
		chk("trimValid first", 32'h0000_0001, 32'(trimValid));
		chk("trimData first", 32'(e1), 32'(trimData));
		@(posedge clk);
		#1;
		chk("trimValid second", 32'h0000_0001, 32'(trimValid));
		chk("trimData second", 32'(e2), 32'(trimData));
		@(posedge clk);
		#1;
		chk("trimValid after", 32'h0000_0000, 32'(trimValid));
		@(posedge clk);
	endtask

	task automatic setCtrl(input logic g, input logic o);
		// Enables sit in the upper byte, so only the upper strobe is given
		wrChk(12'h00C, {16'h0000, 3'h0, g, 3'h0, o, 8'h00}, 4'b0010, RESP_OKAY);
		gEnM = g;
		oEnM = o;
	endtask

	task automatic testReset();
		for (int k = 0; k < 5; k++) begin
			rdChk(12'((32'h31 + k) * 4), 32'h0000_0000, RESP_OKAY);
		end
		rdChk(12'h00C, 32'h0000_0000, RESP_OKAY);
	endtask

	task automatic testMap();
		// Distinct words everywhere expose any aliasing between indices
		for (int k = 0; k < 5; k++) begin
			wrChk(12'((32'h31 + k) * 4), {16'h0000, TRIM_VAL[k]}, 4'hF, RESP_OKAY);
			shadow[k] = TRIM_VAL[k];
		end
		wrChk(12'h0C4, 32'h0000_0000, 4'b0001, RESP_OKAY);
		shadow[0][7:0] = 8'h00;
		// Single-lane writes must leave the other byte alone
		wrChk(12'h0CC, 32'h0000_AA55, 4'b0010, RESP_OKAY);
		shadow[2][15:8] = 8'hAA;
		wrChk(12'h0D0, 32'h0000_00C3, 4'b0001, RESP_OKAY);
		shadow[3][7:0] = 8'hC3;
		wrChk(12'h0E0, 32'h0000_FFFF, 4'hF, RESP_SLVERR);
		rdChk(12'h0E0, 32'h0000_0000, RESP_SLVERR);
		rdChk(12'h0C6, 32'h0000_0000, RESP_SLVERR);
		for (int k = 0; k < 5; k++) begin
			rdChk(12'((32'h31 + k) * 4), {16'h0000, shadow[k]}, RESP_OKAY);
		end
	endtask

	task automatic testBypass();
		pair(3'h0, 1000, 3'h1, -1000);
		pair(3'h2, 8191, 3'h3, -8192);
		pair(3'h4, 77, 3'h7, 55);
		rdChk(12'h0D0, {16'h0000, shadow[3]}, RESP_OKAY);
	endtask

	task automatic testOffset();
		setCtrl(1'b0, 1'b1);
		pair(3'h0, 100, 3'h1, 100);
		pair(3'h2, -7000, 3'h3, 300);
		pair(3'h4, 8000, 3'h5, 8000);
	endtask

	task automatic testGain();
		setCtrl(1'b1, 1'b0);
		pair(3'h0, 1000, 3'h1, 1000);
		pair(3'h2, -3000, 3'h3, 4000);
		pair(3'h4, 6000, 3'h6, 6000);
		setCtrl(1'b1, 1'b1);
		pair(3'h0, -8192, 3'h1, 4000);
	endtask

	task automatic testRes();
		// Coarser output: one offset count stays one 14-bit step, so it shrinks
		setCtrl(1'b0, 1'b1);
		wrChk(12'h100, 32'h0000_0002, 4'b0001, RESP_OKAY);
		shiftM = 4;
		pair(3'h4, 200, 3'h3, -500);
		wrChk(12'h100, 32'h0000_0001, 4'b0001, RESP_OKAY);
		shiftM = 2;
		pair(3'h2, 900, 3'h0, -2048);
		wrChk(12'h100, 32'h0000_0000, 4'b0001, RESP_OKAY);
		shiftM = 0;
		setCtrl(1'b0, 1'b0);
		pair(3'h1, 500, 3'h2, -500);
	endtask

	// Main sequence
	initial begin
		shadow = '0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		testReset();
		testMap();
		testBypass();
		testOffset();
		testGain();
		testRes();
		conclude();
	end

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		#100000;
		errors++;
		conclude();
	end
endmodule
`default_nettype wire
